// [timing_defs.svh]
// Purpose: shared constants of the instruction timing sequencer
// Assumes: packed byte/cycle word is {bytes[2:0], cycles[2:0]}
// Notes:   a zero word marks an illegal class/mode pairing
`ifndef TIMING_DEFS_SVH
`define TIMING_DEFS_SVH

`define BC_ILLEGAL   6'h00
`define BC_1_1       6'h09
`define BC_1_2       6'h0A
`define BC_1_3       6'h0B
`define BC_1_5       6'h0D
`define BC_1_7       6'h0F
`define BC_2_2       6'h12
`define BC_2_3       6'h13
`define BC_2_5       6'h15
`define BC_3_3       6'h1B
`define BC_3_4       6'h1C
`define BC_3_5       6'h1D

// first pointer value that needs the long encoding
`define B_SHORT_LIMIT 8'h10

`define CNT_W        3

`endif

// [timing_pkg.sv]
// Purpose: types of the instruction timing sequencer
// Assumes: nothing beyond the shared constants
// Notes:   class codes are this block's own, not opcode values
`default_nettype none
package timing_pkg;

  typedef enum logic [4:0] {
    OP_ADD                  = 5'h00,
    OP_ADD_CARRY            = 5'h01,
    OP_SUBTRACT_WITH_CARRY  = 5'h02,
    OP_AND                  = 5'h03,
    OP_OR                   = 5'h04,
    OP_XOR                  = 5'h05,
    OP_SKIP_UNLESS_EQUAL    = 5'h06,
    OP_SKIP_UNLESS_GREATER  = 5'h07,
    OP_SWAP_ACC             = 5'h08,
    OP_LOAD_MOVE_ACC        = 5'h09,
    OP_LOAD_MOVE_B          = 5'h0A,
    OP_LOAD_MOVE_MEM        = 5'h0B,
    OP_LOAD_MOVE_REG        = 5'h0C,
    OP_TABLE_LOOKUP_LOAD    = 5'h0D,
    OP_DECIMAL_CORRECT_ACC  = 5'h0E,
    OP_LONG_SUBROUTINE_CALL = 5'h0F,
    OP_SHORT_SUBROUTINE_CALL= 5'h10,
    OP_INTERRUPT_RETURN     = 5'h11,
    OP_SOFTWARE_TRAP        = 5'h12,
    OP_NOP                  = 5'h13
  } op_t;

  typedef enum logic [2:0] {
    MODE_NONE   = 3'h0,
    MODE_B_IND  = 3'h1,
    MODE_X_IND  = 3'h2,
    MODE_DIRECT = 3'h3,
    MODE_IMM    = 3'h4,
    MODE_B_STEP = 3'h5,
    MODE_X_STEP = 3'h6
  } mode_t;

  typedef struct packed {
    logic [2:0] bytes;
    logic [2:0] cycles;
  } bc_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_EXEC = 2'h1,
    ST_SKIP = 2'h2
  } seq_state_t;

  function automatic logic is_alu(op_t op);
    return op inside {OP_ADD, OP_ADD_CARRY, OP_SUBTRACT_WITH_CARRY,
                      OP_AND, OP_OR, OP_XOR};
  endfunction : is_alu

  function automatic logic is_compare(op_t op);
    return op inside {OP_SKIP_UNLESS_EQUAL, OP_SKIP_UNLESS_GREATER};
  endfunction : is_compare

endpackage : timing_pkg
`default_nettype wire

// [timing_if.sv]
// Purpose: carries a class/mode query and its byte/cycle answer
// Assumes: answer is combinational on the query
// Notes:   none
`timescale 1ns/1ns
`default_nettype none
interface timing_if
  import timing_pkg::*;
  ();
  op_t        op;
  mode_t      mode;
  logic [7:0] imm;
  bc_t        bc;

  modport table_side (input op, input mode, input imm, output bc);
  modport user_side  (output op, output mode, output imm, input bc);
endinterface : timing_if
`default_nettype wire

// [timing_lookup.sv]
// Purpose: byte and cycle figures for each class and addressing mode
// Assumes: query stable for the cycle it is used in
// Notes:   unlisted pairings answer with the illegal word
`timescale 1ns/1ns
`default_nettype none
`include "timing_defs.svh"
module timing_lookup
  import timing_pkg::*;
(
  timing_if.table_side q
);

  // three-column operand timing shared by math, logic and compares
  function automatic bc_t alu_bc(mode_t m);
    case (m)
      MODE_B_IND:  return `BC_1_1;
      MODE_DIRECT: return `BC_3_4;
      MODE_IMM:    return `BC_2_2;
      default:     return `BC_ILLEGAL;
    endcase
  endfunction : alu_bc

  function automatic bc_t acc_move_bc(mode_t m, logic imm_ok);
    case (m)
      MODE_B_IND:  return `BC_1_1;
      MODE_X_IND:  return `BC_1_3;
      MODE_DIRECT: return `BC_2_3;
      MODE_IMM:    return imm_ok ? `BC_2_2 : `BC_ILLEGAL;
      MODE_B_STEP: return `BC_1_2;
      MODE_X_STEP: return `BC_1_3;
      default:     return `BC_ILLEGAL;
    endcase
  endfunction : acc_move_bc

  function automatic bc_t decode(op_t op, mode_t m, logic [7:0] imm);
    bc_t r;
    r = `BC_ILLEGAL;
    case (op)
      OP_ADD, OP_ADD_CARRY, OP_SUBTRACT_WITH_CARRY: begin
        r = alu_bc(m);
      end
      OP_AND, OP_OR, OP_XOR: begin
        r = alu_bc(m);
      end
      OP_SKIP_UNLESS_EQUAL, OP_SKIP_UNLESS_GREATER: begin
        r = alu_bc(m);
      end
      OP_SWAP_ACC: begin
        r = acc_move_bc(m, 1'b0);
      end
      OP_LOAD_MOVE_ACC: begin
        r = acc_move_bc(m, 1'b1);
      end
      OP_LOAD_MOVE_B: begin
        if (m == MODE_IMM) begin
          // short form only reaches the lowest sixteen locations
          r = (imm < `B_SHORT_LIMIT) ? `BC_1_1
                                     : `BC_2_3;
        end
      end
      OP_LOAD_MOVE_MEM: begin
        if (m == MODE_DIRECT) begin
          r = `BC_3_3;
        end else if (m == MODE_B_STEP) begin
          r = `BC_2_2;
        end
      end
      OP_LOAD_MOVE_REG: begin
        if (m == MODE_IMM) begin
          r = `BC_2_3;
        end
      end
      OP_TABLE_LOOKUP_LOAD: begin
        if (m == MODE_NONE) begin
          r = `BC_1_3;
        end
      end
      OP_DECIMAL_CORRECT_ACC: begin
        if (m == MODE_NONE) begin
          r = `BC_1_1;
        end
      end
      OP_LONG_SUBROUTINE_CALL: begin
        if (m == MODE_NONE) begin
          r = `BC_3_5;
        end
      end
      OP_SHORT_SUBROUTINE_CALL: begin
        if (m == MODE_NONE) begin
          r = `BC_2_5;
        end
      end
      OP_INTERRUPT_RETURN: begin
        if (m == MODE_NONE) begin
          r = `BC_1_5;
        end
      end
      OP_SOFTWARE_TRAP: begin
        if (m == MODE_NONE) begin
          r = `BC_1_7;
        end
      end
      OP_NOP: begin
        if (m == MODE_NONE) begin
          r = `BC_1_1;
        end
      end
      default: begin
        r = `BC_ILLEGAL;
      end
    endcase
    return r;
  endfunction : decode

  assign q.bc = decode(q.op, q.mode, q.imm);

endmodule : timing_lookup
`default_nettype wire

// [instruction_cycle_timing.sv]
// Purpose: paces each instruction over its documented cycle count
// Assumes: one instruction cycle per clk; inputs synchronous to clk
// Notes:   skip request is honoured only in a compare's last cycle
//
// Notes on behaviour
// - add, add with carry, subtract_with_carry: 1/1, 3/4, 2/2 by mode.
// - and, or, xor: 1/1 pointer-B, 3/4 direct, 2/2 immediate.
// - skip_unless_equal/greater compares: 1/1, 3/4, 2/2 by mode.
// - swap acc: B 1/1, X 1/3, direct 2/3, B-step 1/2, X-step 1/3.
// - load acc: as swap, plus immediate 2/2.
// - load B with immediate below 16: one byte, one cycle.
// - load B with immediate above 15: two bytes, three cycles.
// - store immediate direct 3/3; through stepping B 2/2.
// - load immediate into working register: two bytes, three cycles.
// - table_lookup_load 1/3; decimal_correct_acc 1/1.
// - long_subroutine_call 3/5; short_subroutine_call 2/5.
// - interrupt_return 1/5; software_trap 1/7.
// - a skipped instruction costs one cycle per opcode byte.
`timescale 1ns/1ns
`default_nettype none
`include "timing_defs.svh"
module instruction_cycle_timing
  import timing_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       issue_valid,
  input  wire op_t        issue_op,
  input  wire mode_t      issue_mode,
  input  wire logic [7:0] issue_imm,
  input  wire logic       skip_next,
  output logic            issue_ready,
  output logic            busy,
  output logic            skipping,
  output logic            retire,
  output logic [2:0]      cur_bytes,
  output logic            bad_op
);

  timing_if tq ();

  seq_state_t            state_q;
  logic [`CNT_W-1:0]     remain_q;
  logic                  ready_q;
  logic                  compare_q;
  logic                  skip_armed_q;
  logic                  retire_q;
  logic [2:0]            bytes_q;
  logic                  bad_q;
  logic                  busy_q;
  logic                  skipping_q;
  logic                  legal;
  logic                  accept;
  logic                  skip_req;
  logic                  skip_eff;
  logic [`CNT_W-1:0]     span;
  logic                  last_cycle;

  assign tq.op   = issue_op;
  assign tq.mode = issue_mode;
  assign tq.imm  = issue_imm;

  timing_lookup u_lookup (
    .q (tq.table_side)
  );

  assign legal      = (tq.bc.bytes != 3'h0);
  assign accept     = issue_valid && ready_q && legal;
  assign last_cycle = (state_q != ST_IDLE) && (remain_q == 3'h0);
  // a failed compare asks to drop the instruction that follows it
  assign skip_req   = skip_next && compare_q && last_cycle;
  assign skip_eff   = skip_armed_q || skip_req;
  // a skipped instruction burns one cycle per byte, not its own count
  assign span       = skip_eff ? tq.bc.bytes : tq.bc.cycles;

  // sequencer: one count per clk, fetch held until it runs out
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q    <= ST_IDLE;
      remain_q   <= 3'h0;
      ready_q    <= 1'b1;
      busy_q     <= 1'b0;
      skipping_q <= 1'b0;
    end else if (accept) begin
      state_q    <= skip_eff ? ST_SKIP : ST_EXEC;
      remain_q   <= span - 3'h1;
      ready_q    <= (span == 3'h1);
      busy_q     <= 1'b1;
      skipping_q <= skip_eff;
    end else begin
      case (state_q)
        ST_IDLE: begin
          ready_q <= 1'b1;
        end
        ST_EXEC, ST_SKIP: begin
          if (remain_q == 3'h0) begin
            state_q    <= ST_IDLE;
            ready_q    <= 1'b1;
            busy_q     <= 1'b0;
            skipping_q <= 1'b0;
          end else begin
            remain_q <= remain_q - 3'h1;
            // reopen fetch for the last cycle so instructions abut
            ready_q  <= (remain_q == 3'h1);
          end
        end
        default: begin
          state_q    <= ST_IDLE;
          remain_q   <= 3'h0;
          ready_q    <= 1'b1;
          busy_q     <= 1'b0;
          skipping_q <= 1'b0;
        end
      endcase
    end
  end

  // remembered skip survives gaps until the next fetch consumes it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      skip_armed_q <= 1'b0;
    end else if (accept) begin
      skip_armed_q <= 1'b0;
    end else if (skip_req) begin
      skip_armed_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      compare_q <= 1'b0;
      bytes_q   <= 3'h0;
    end else if (accept) begin
      // a skipped compare cannot itself cause a skip
      compare_q <= is_compare(issue_op) && !skip_eff;
      bytes_q   <= tq.bc.bytes;
    end else if (last_cycle) begin
      compare_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      retire_q <= 1'b0;
    end else begin
      retire_q <= last_cycle;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bad_q <= 1'b0;
    end else begin
      bad_q <= issue_valid && ready_q && !legal;
    end
  end

  assign issue_ready = ready_q;
  // flop copies of the state so these pins leave straight from registers
  assign busy        = busy_q;
  assign skipping    = skipping_q;
  assign retire      = retire_q;
  assign cur_bytes   = bytes_q;
  assign bad_op      = bad_q;

  // checks on pacing
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic plain;
  assign plain = accept && !skip_eff;

  a_alu_direct_len: assert property (
    plain && issue_op inside {OP_ADD, OP_ADD_CARRY, OP_SUBTRACT_WITH_CARRY}
      && issue_mode == MODE_DIRECT |=> !ready_q [*3] ##1 ready_q)
    else $error("math direct not four cycles");

  a_logic_imm_len: assert property (
    plain && issue_op inside {OP_AND, OP_OR, OP_XOR}
      && issue_mode == MODE_IMM |=> !ready_q ##1 ready_q && cur_bytes == 3'h2)
    else $error("logic immediate not two bytes two cycles");

  a_cmp_ind_len: assert property (
    plain && is_compare(issue_op) && issue_mode == MODE_B_IND
      |=> ready_q && cur_bytes == 3'h1 ##1 retire_q)
    else $error("compare pointer-B not one cycle");

  a_swap_x_len: assert property (
    plain && issue_op == OP_SWAP_ACC && issue_mode == MODE_X_IND
      |=> !ready_q [*2] ##1 ready_q)
    else $error("swap through X not three cycles");

  a_load_bstep_len: assert property (
    plain && issue_op == OP_LOAD_MOVE_ACC && issue_mode == MODE_B_STEP
      |=> !ready_q ##1 ready_q && cur_bytes == 3'h1)
    else $error("load acc B-step not 1/2");

  a_b_short_len: assert property (
    plain && issue_op == OP_LOAD_MOVE_B && issue_imm < 8'h10
      |=> ready_q && cur_bytes == 3'h1)
    else $error("short pointer load not 1/1");

  a_b_long_len: assert property (
    plain && issue_op == OP_LOAD_MOVE_B && issue_imm > 8'h0F
      && issue_mode == MODE_IMM |=> !ready_q [*2] ##1 ready_q)
    else $error("long pointer load not three cycles");

  a_store_direct_len: assert property (
    plain && issue_op == OP_LOAD_MOVE_MEM && issue_mode == MODE_DIRECT
      |=> cur_bytes == 3'h3 && !ready_q ##1 !ready_q ##1 ready_q)
    else $error("direct store not 3/3");

  a_reg_load_len: assert property (
    plain && issue_op == OP_LOAD_MOVE_REG && issue_mode == MODE_IMM
      |=> !ready_q [*2] ##1 ready_q)
    else $error("register load not three cycles");

  a_lookup_len: assert property (
    plain && issue_op == OP_TABLE_LOOKUP_LOAD
      |=> !ready_q [*2] ##1 ready_q ##1 retire_q)
    else $error("table lookup not three cycles");

  a_call_len: assert property (
    plain && issue_op == OP_SHORT_SUBROUTINE_CALL
      |=> !ready_q [*4] ##1 ready_q && cur_bytes == 3'h2)
    else $error("short call not 2/5");

  a_trap_len: assert property (
    plain && issue_op == OP_SOFTWARE_TRAP |=> !ready_q [*6] ##1 ready_q)
    else $error("trap not seven cycles");

  a_skip_bytes: assert property (
    accept && skip_eff && tq.bc.bytes == 3'h3
      |=> skipping [*3] ##1 !skipping || $past(accept))
    else $error("skip did not last three cycles");

  a_fetch_hold: assert property (
    busy && remain_q > 3'h1 |-> !ready_q ##1 busy)
    else $error("fetch reopened before count ran out");

  a_logic_direct_len: assert property (
    plain && issue_op inside {OP_AND, OP_OR, OP_XOR}
      && issue_mode == MODE_DIRECT |=> !ready_q [*3] ##1 ready_q)
    else $error("logic direct not four cycles");

  a_alu_imm_len: assert property (
    plain && is_alu(issue_op) && issue_mode == MODE_IMM
      |=> cur_bytes == 3'h2 && !ready_q ##1 ready_q)
    else $error("arithmetic immediate not 2/2");

  a_cmp_direct_len: assert property (
    plain && is_compare(issue_op) && issue_mode == MODE_DIRECT
      |=> (cur_bytes == 3'h3 && !ready_q) [*3] ##1 ready_q)
    else $error("compare direct not 3/4");

  a_swap_direct_len: assert property (
    plain && issue_op == OP_SWAP_ACC && issue_mode == MODE_DIRECT
      |=> (cur_bytes == 3'h2 && !ready_q) [*2] ##1 ready_q)
    else $error("swap direct not 2/3");

  a_load_imm_len: assert property (
    plain && issue_op == OP_LOAD_MOVE_ACC && issue_mode == MODE_IMM
      |=> !ready_q ##1 ready_q && cur_bytes == 3'h2)
    else $error("load acc immediate not 2/2");

  a_store_step_len: assert property (
    plain && issue_op == OP_LOAD_MOVE_MEM && issue_mode == MODE_B_STEP
      |=> !ready_q ##1 ready_q && cur_bytes == 3'h2)
    else $error("store through stepping B not 2/2");

  a_decimal_len: assert property (
    plain && issue_op == OP_DECIMAL_CORRECT_ACC
      |=> ready_q && cur_bytes == 3'h1)
    else $error("decimal correct not 1/1");

  a_long_call_len: assert property (
    plain && issue_op == OP_LONG_SUBROUTINE_CALL
      |=> (cur_bytes == 3'h3 && !ready_q) [*4] ##1 ready_q)
    else $error("long call not 3/5");

  a_return_len: assert property (
    plain && issue_op == OP_INTERRUPT_RETURN
      |=> (cur_bytes == 3'h1 && !ready_q) [*4] ##1 ready_q)
    else $error("interrupt return not 1/5");

  a_skip_single: assert property (
    accept && skip_eff && tq.bc.bytes == 3'h1 |=> skipping && ready_q)
    else $error("one-byte skip not one cycle");

  a_skip_no_chain: assert property (
    accept && skip_eff |=> !compare_q)
    else $error("skipped compare armed a further skip");

  a_retire_pulse: assert property (
    last_cycle && !accept |=> retire && !busy ##1 !retire)
    else $error("retire not a single pulse after the last cycle");

  c_skip_seen:  cover property (accept && skip_eff);
  c_trap_run:   cover property (plain && issue_op == OP_SOFTWARE_TRAP);
  c_b_long:     cover property (plain && issue_op == OP_LOAD_MOVE_B
                                && issue_imm > 8'h0F);
  c_back2back:  cover property (accept ##1 accept ##1 accept);
  c_skip_armed: cover property (accept && skip_armed_q);

endmodule : instruction_cycle_timing
`default_nettype wire

// [instruction_cycle_timing_tb.sv]
// Purpose: self-checking bench for the instruction timing sequencer
// Assumes: inputs change and outputs are read on the falling edge
// Notes:   spans are counted in falling edges after the accept edge
`timescale 1ns/1ns
`default_nettype none
module instruction_cycle_timing_tb
  import timing_pkg::*;
();
  logic       clk;
  logic       arst_n;
  logic       issue_valid;
  op_t        issue_op;
  mode_t      issue_mode;
  logic [7:0] issue_imm;
  logic       skip_next;
  logic       issue_ready;
  logic       busy;
  logic       skipping;
  logic       retire;
  logic [2:0] cur_bytes;
  logic       bad_op;
  int         num_errors;
  int         checks_done;

  instruction_cycle_timing dut_u (
    .clk         (clk),
    .arst_n      (arst_n),
    .issue_valid (issue_valid),
    .issue_op    (issue_op),
    .issue_mode  (issue_mode),
    .issue_imm   (issue_imm),
    .skip_next   (skip_next),
    .issue_ready (issue_ready),
    .busy        (busy),
    .skipping    (skipping),
    .retire      (retire),
    .cur_bytes   (cur_bytes),
    .bad_op      (bad_op)
  );

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic cmp_bit(string what, logic exp, logic got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %b, seen %b", what, exp, got);
    end
  endtask : cmp_bit

  task automatic cmp3(string what, logic [2:0] exp, logic [2:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask : cmp3

  task automatic cmp_cnt(string what, int exp, int got);
    checks_done++;
    if (got != exp) begin
      num_errors++;
      $display("wrong value %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask : cmp_cnt

  // counts cycles until fetch reopens; bounded so a stuck core ends the run
  task automatic wait_span(string what, int exp);
    int n;
    n = 1;
    while (issue_ready !== 1'h1) begin
      if (n > 12) begin
        num_errors++;
        $display("wrong value %s: expected ready, seen timeout", what);
        end_of_test();
      end
      @(negedge clk);
      n++;
    end
    cmp_cnt(what, exp, n);
  endtask : wait_span

  task automatic run_op(op_t op, mode_t md, logic [7:0] imm,
                        logic [2:0] nb, int cyc);
    issue_valid = 1'h1;
    issue_op    = op;
    issue_mode  = md;
    issue_imm   = imm;
    @(posedge clk);
    @(negedge clk);
    issue_valid = 1'h0;
    cmp3(op.name(), nb, cur_bytes);
    cmp_bit("busy", 1'h1, busy);
    cmp_bit("skipping", 1'h0, skipping);
    wait_span(op.name(), cyc);
    @(negedge clk);
    cmp_bit("retire", 1'h1, retire);
    cmp_bit("busy", 1'h0, busy);
  endtask : run_op

  task automatic alu3(op_t op);
    run_op(op, MODE_B_IND, 8'h00, 3'h1, 1);
    run_op(op, MODE_DIRECT, 8'h00, 3'h3, 4);
    run_op(op, MODE_IMM, 8'h00, 3'h2, 2);
  endtask : alu3

  task automatic mem5(op_t op);
    run_op(op, MODE_B_IND, 8'h00, 3'h1, 1);
    run_op(op, MODE_X_IND, 8'h00, 3'h1, 3);
    run_op(op, MODE_DIRECT, 8'h00, 3'h2, 3);
    run_op(op, MODE_B_STEP, 8'h00, 3'h1, 2);
    run_op(op, MODE_X_STEP, 8'h00, 3'h1, 3);
  endtask : mem5

  task automatic test_alu();
    alu3(OP_ADD);
    alu3(OP_ADD_CARRY);
    alu3(OP_SUBTRACT_WITH_CARRY);
    alu3(OP_AND);
    alu3(OP_OR);
    alu3(OP_XOR);
    alu3(OP_SKIP_UNLESS_EQUAL);
    alu3(OP_SKIP_UNLESS_GREATER);
    $display("test alu done");
  endtask : test_alu

  task automatic test_transfer();
    mem5(OP_SWAP_ACC);
    mem5(OP_LOAD_MOVE_ACC);
    run_op(OP_LOAD_MOVE_ACC, MODE_IMM, 8'h00, 3'h2, 2);
    run_op(OP_LOAD_MOVE_B, MODE_IMM, 8'h0F, 3'h1, 1);
    run_op(OP_LOAD_MOVE_B, MODE_IMM, 8'h10, 3'h2, 3);
    run_op(OP_LOAD_MOVE_B, MODE_IMM, 8'hFF, 3'h2, 3);
    run_op(OP_LOAD_MOVE_MEM, MODE_DIRECT, 8'h00, 3'h3, 3);
    run_op(OP_LOAD_MOVE_MEM, MODE_B_STEP, 8'h00, 3'h2, 2);
    run_op(OP_LOAD_MOVE_REG, MODE_IMM, 8'h00, 3'h2, 3);
    $display("test transfer done");
  endtask : test_transfer

  task automatic test_control();
    run_op(OP_TABLE_LOOKUP_LOAD, MODE_NONE, 8'h00, 3'h1, 3);
    run_op(OP_DECIMAL_CORRECT_ACC, MODE_NONE, 8'h00, 3'h1, 1);
    run_op(OP_LONG_SUBROUTINE_CALL, MODE_NONE, 8'h00, 3'h3, 5);
    run_op(OP_SHORT_SUBROUTINE_CALL, MODE_NONE, 8'h00, 3'h2, 5);
    run_op(OP_INTERRUPT_RETURN, MODE_NONE, 8'h00, 3'h1, 5);
    run_op(OP_SOFTWARE_TRAP, MODE_NONE, 8'h00, 3'h1, 7);
    $display("test control done");
  endtask : test_control

  // failed compare followed at once by the victim, valid held throughout
  task automatic test_skip(op_t cmp, op_t op, mode_t md, logic [2:0] nb);
    issue_valid = 1'h1;
    issue_op    = cmp;
    issue_mode  = MODE_B_IND;
    @(posedge clk);
    @(negedge clk);
    cmp_bit("ready", 1'h1, issue_ready);
    issue_op   = op;
    issue_mode = md;
    skip_next  = 1'h1;
    @(posedge clk);
    @(negedge clk);
    issue_valid = 1'h0;
    skip_next   = 1'h0;
    cmp_bit("skipping", 1'h1, skipping);
    cmp3("skipped bytes", nb, cur_bytes);
    wait_span("skip span", int'(nb));
    @(negedge clk);
    cmp_bit("skipping", 1'h0, skipping);
    cmp_bit("busy", 1'h0, busy);
    $display("test skip %s done", op.name());
  endtask : test_skip

  // next fetch taken on the very edge the count runs out
  task automatic test_back_to_back();
    issue_valid = 1'h1;
    issue_op    = OP_ADD;
    issue_mode  = MODE_DIRECT;
    @(posedge clk);
    @(negedge clk);
    issue_mode = MODE_B_IND;
    wait_span("first span", 4);
    @(negedge clk);
    issue_valid = 1'h0;
    cmp3("second bytes", 3'h1, cur_bytes);
    cmp_bit("busy", 1'h1, busy);
    wait_span("second span", 1);
    @(negedge clk);
    cmp_bit("retire", 1'h1, retire);
    $display("test back_to_back done");
  endtask : test_back_to_back

  task automatic test_refuse(op_t op, mode_t md);
    issue_valid = 1'h1;
    issue_op    = op;
    issue_mode  = md;
    @(posedge clk);
    @(negedge clk);
    issue_valid = 1'h0;
    cmp_bit("bad_op", 1'h1, bad_op);
    cmp_bit("busy", 1'h0, busy);
    cmp_bit("ready", 1'h1, issue_ready);
    @(negedge clk);
    cmp_bit("bad_op", 1'h0, bad_op);
    $display("test refuse %s done", op.name());
  endtask : test_refuse

  // failed compare with no successor: the skip waits for the next fetch
  task automatic test_skip_gap();
    issue_valid = 1'h1;
    issue_op    = OP_SKIP_UNLESS_EQUAL;
    issue_mode  = MODE_B_IND;
    @(posedge clk);
    @(negedge clk);
    issue_valid = 1'h0;
    skip_next   = 1'h1;
    @(posedge clk);
    @(negedge clk);
    cmp_bit("gap busy", 1'h0, busy);
    issue_valid = 1'h1;
    issue_op    = OP_SKIP_UNLESS_GREATER;
    issue_mode  = MODE_DIRECT;
    @(posedge clk);
    @(negedge clk);
    issue_valid = 1'h0;
    cmp_bit("armed skipping", 1'h1, skipping);
    cmp3("armed skipped bytes", 3'h3, cur_bytes);
    wait_span("armed skip span", 3);
    // skip_next still high: a skipped compare must not skip again
    run_op(OP_ADD, MODE_IMM, 8'h00, 3'h2, 2);
    skip_next = 1'h0;
    $display("test skip_gap done");
  endtask : test_skip_gap

  // reset in mid-instruction drops the count and reopens fetch
  task automatic test_reset_mid();
    issue_valid = 1'h1;
    issue_op    = OP_SOFTWARE_TRAP;
    issue_mode  = MODE_NONE;
    @(posedge clk);
    @(negedge clk);
    issue_valid = 1'h0;
    @(negedge clk);
    arst_n = 1'h0;
    @(posedge clk);
    @(negedge clk);
    cmp_bit("mid reset ready", 1'h1, issue_ready);
    cmp_bit("mid reset busy", 1'h0, busy);
    cmp_bit("mid reset skipping", 1'h0, skipping);
    cmp_bit("mid reset retire", 1'h0, retire);
    cmp3("mid reset bytes", 3'h0, cur_bytes);
    arst_n = 1'h1;
    run_op(OP_LOAD_MOVE_B, MODE_IMM, 8'h05, 3'h1, 1);
    $display("test reset_mid done");
  endtask : test_reset_mid

  initial begin
    num_errors  = 0;
    checks_done = 0;
    arst_n      = 1'h0;
    issue_valid = 1'h0;
    issue_op    = OP_NOP;
    issue_mode  = MODE_NONE;
    issue_imm   = 8'h00;
    skip_next   = 1'h0;
    repeat (16) @(negedge clk);
    cmp_bit("reset ready", 1'h1, issue_ready);
    cmp_bit("reset busy", 1'h0, busy);
    cmp3("reset bytes", 3'h0, cur_bytes);
    arst_n = 1'h1;
    run_op(OP_NOP, MODE_NONE, 8'h00, 3'h1, 1);
    test_alu();
    test_transfer();
    test_control();
    test_skip(OP_SKIP_UNLESS_EQUAL, OP_ADD, MODE_DIRECT, 3'h3);
    test_skip(OP_SKIP_UNLESS_GREATER, OP_TABLE_LOOKUP_LOAD, MODE_NONE, 3'h1);
    test_back_to_back();
    test_skip_gap();
    test_reset_mid();
    test_refuse(OP_SWAP_ACC, MODE_IMM);
    test_refuse(OP_NOP, MODE_B_IND);
    end_of_test();
  end
endmodule : instruction_cycle_timing_tb
`default_nettype wire
